// *** wrcrf_regs.vh ***
// Register map, field layout and reset values of the wake and reset flag bank
`ifndef WRCRF_REGS_VH
`define WRCRF_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define WRCRF_ADDR_W 5
`define WRCRF_OFS_CLEAR 5'h00
`define WRCRF_OFS_NMI 5'h04
`define WRCRF_OFS_RSTC 5'h08
`define WRCRF_OFS_IRQST 5'h0C
`define WRCRF_OFS_IRQMSK 5'h10

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define WRCRF_SEL_W 5
`define WRCRF_NSRC 11
`define WRCRF_SRC_VALID 11'h73F
`define WRCRF_NMI_WDT_BIT 0
`define WRCRF_NMI_PIN_BIT 1
`define WRCRF_RST_PON_BIT 0
`define WRCRF_RST_PIN_BIT 1
`define WRCRF_RST_WDT_BIT 2
`define WRCRF_RST_SOFT_BIT 4
`define WRCRF_RST_USED 5'h17
`define WRCRF_IRQ_W 3
`define WRCRF_IRQ_NMIPIN_BIT 0
`define WRCRF_IRQ_NMIWDT_BIT 1
`define WRCRF_IRQ_WAKE_BIT 2

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define WRCRF_RST_PON_VAL 5'h01
`define WRCRF_RESP_OKAY 2'h0
`define WRCRF_RESP_SLVERR 2'h2

`endif

// *** wrcrf_top.v ***
// Wake request clear, NMI source and reset cause flag bank on AXI4-Lite
`include "wrcrf_regs.vh"

module wrcrf_top #(
    parameter NSRC = `WRCRF_NSRC
) (
    input wire clk,
    input wire reset_n,
    input wire power_on_n,
    // AXI4-Lite slave
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [`WRCRF_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    output wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [`WRCRF_ADDR_W-1:0] s_axi_araddr,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    // Wake sources, indexed by selector code
    input wire [NSRC-1:0] wake_req_set,
    input wire [2*NSRC-1:0] wake_edge_in,
    output wire [NSRC-1:0] wake_pending,
    output wire [2*NSRC-1:0] active_edge_status,
    output wire [NSRC-1:0] wake_clear_pulse,
    // NMI sources
    input wire nmi_pin_event,
    input wire nmi_watchdog_event,
    // Reset causes, held stable by the reset controller over release
    input wire reset_cause_pin,
    input wire reset_cause_watchdog,
    input wire cpu_soft_reset_request,
    output wire irq
);

// ----------------------------------------------------------------------
// Reset synchronisers
// ----------------------------------------------------------------------
reg rst_meta_r;
reg rst_sync_r;
reg pon_meta_r;
reg pon_sync_r;

// Release of the system reset through two flops
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        rst_meta_r <= 1'b0;
        rst_sync_r <= 1'b0;
    end else begin
        rst_meta_r <= 1'b1;
        rst_sync_r <= rst_meta_r;
    end
end
// Release of the power-on reset through two flops
always @(posedge clk or negedge power_on_n) begin
    if (!power_on_n) begin
        pon_meta_r <= 1'b0;
        pon_sync_r <= 1'b0;
    end else begin
        pon_meta_r <= 1'b1;
        pon_sync_r <= pon_meta_r;
    end
end

// ----------------------------------------------------------------------
// AXI4-Lite write channel
// ----------------------------------------------------------------------
reg aw_held_r;
reg w_held_r;
reg [`WRCRF_ADDR_W-1:0] awaddr_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg bvalid_r;
reg [1:0] bresp_r;
wire wr_do;
wire [31:0] wmask;
wire wr_hit_clear;
wire wr_hit_rstc;
wire wr_hit_irqst;
wire wr_hit_irqmsk;
wire wr_mapped;

assign s_axi_awready = !aw_held_r && !bvalid_r;
assign s_axi_wready = !w_held_r && !bvalid_r;
assign s_axi_bvalid = bvalid_r;
assign s_axi_bresp = bresp_r;
assign wr_do = aw_held_r && w_held_r && !bvalid_r;
assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
assign wr_hit_clear = wr_do && (awaddr_r == `WRCRF_OFS_CLEAR);
assign wr_hit_rstc = wr_do && (awaddr_r == `WRCRF_OFS_RSTC);
assign wr_hit_irqst = wr_do && (awaddr_r == `WRCRF_OFS_IRQST);
assign wr_hit_irqmsk = wr_do && (awaddr_r == `WRCRF_OFS_IRQMSK);
assign wr_mapped = (awaddr_r == `WRCRF_OFS_CLEAR) ||
                   (awaddr_r == `WRCRF_OFS_NMI) ||
                   (awaddr_r == `WRCRF_OFS_RSTC) ||
                   (awaddr_r == `WRCRF_OFS_IRQST) ||
                   (awaddr_r == `WRCRF_OFS_IRQMSK);

// Address and data are taken in either order, then one response
always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        awaddr_r <= {`WRCRF_ADDR_W{1'b0}};
        wdata_r <= 32'h00000000;
        wstrb_r <= 4'h0;
        bvalid_r <= 1'b0;
        bresp_r <= `WRCRF_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[`WRCRF_ADDR_W-1:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        if (wr_do) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_mapped ? `WRCRF_RESP_OKAY : `WRCRF_RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------
// Wake request clear
// ----------------------------------------------------------------------
reg [NSRC-1:0] wake_pend_r;
reg [2*NSRC-1:0] edge_stat_r;
reg [NSRC-1:0] clr_onehot;
wire [`WRCRF_SEL_W-1:0] sel_code;
integer i;
integer j;
localparam [NSRC-1:0] SRC_OK = `WRCRF_SRC_VALID;
assign sel_code = wdata_r[`WRCRF_SEL_W-1:0];

// One-hot of the written code; reserved codes select nothing
always @* begin
    clr_onehot = {NSRC{1'b0}};
    for (i = 0; i < NSRC; i = i + 1) begin
        if (wr_hit_clear && wstrb_r[0] && SRC_OK[i] &&
            (sel_code == i[`WRCRF_SEL_W-1:0])) begin
            clr_onehot[i] = 1'b1;
        end
    end
end
// Pending requests and edge status; a new request wins over a clear
always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        wake_pend_r <= {NSRC{1'b0}};
        edge_stat_r <= {2*NSRC{1'b0}};
    end else begin
        for (j = 0; j < NSRC; j = j + 1) begin
            if (wake_req_set[j] && SRC_OK[j]) begin
                wake_pend_r[j] <= 1'b1;
                edge_stat_r[2*j +: 2] <= wake_edge_in[2*j +: 2];
            end else if (clr_onehot[j]) begin
                wake_pend_r[j] <= 1'b0;
                edge_stat_r[2*j +: 2] <= 2'b00;
            end
        end
    end
end
assign wake_pending = wake_pend_r;
assign active_edge_status = edge_stat_r;
assign wake_clear_pulse = clr_onehot;

// ----------------------------------------------------------------------
// AXI4-Lite read channel
// ----------------------------------------------------------------------
reg rvalid_r;
reg [31:0] rdata_r;
reg [1:0] rresp_r;
reg [31:0] rd_val;
reg rd_ok;
wire rd_take;
wire rd_nmi;
wire [`WRCRF_ADDR_W-1:0] rd_addr;
reg [1:0] nmi_flag_r;
reg [4:0] rst_flag_r;
reg [`WRCRF_IRQ_W-1:0] irq_st_r;
reg [`WRCRF_IRQ_W-1:0] irq_msk_r;

assign s_axi_arready = !rvalid_r;
assign s_axi_rvalid = rvalid_r;
assign s_axi_rdata = rdata_r;
assign s_axi_rresp = rresp_r;
assign rd_take = s_axi_arvalid && !rvalid_r;
assign rd_addr = {s_axi_araddr[`WRCRF_ADDR_W-1:2], 2'b00};
assign rd_nmi = rd_take && (rd_addr == `WRCRF_OFS_NMI);

// Read mux; unused and reserved bits read zero
always @* begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (rd_addr == `WRCRF_OFS_CLEAR) begin
        rd_val = 32'h00000000;
    end else if (rd_addr == `WRCRF_OFS_NMI) begin
        rd_val = {30'h00000000, nmi_flag_r};
    end else if (rd_addr == `WRCRF_OFS_RSTC) begin
        rd_val = {27'h0000000, rst_flag_r & `WRCRF_RST_USED};
    end else if (rd_addr == `WRCRF_OFS_IRQST) begin
        rd_val = {29'h00000000, irq_st_r};
    end else if (rd_addr == `WRCRF_OFS_IRQMSK) begin
        rd_val = {29'h00000000, irq_msk_r};
    end else begin
        rd_ok = 1'b0;
    end
end
// Read data is registered one cycle after the address is taken
always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        rvalid_r <= 1'b0;
        rdata_r <= 32'h00000000;
        rresp_r <= `WRCRF_RESP_OKAY;
    end else if (rd_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_ok ? `WRCRF_RESP_OKAY : `WRCRF_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// NMI source flags
// ----------------------------------------------------------------------
// Cleared by the read that returns them; a new event wins
always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        nmi_flag_r <= 2'b00;
    end else begin
        if (nmi_pin_event) begin
            nmi_flag_r[`WRCRF_NMI_PIN_BIT] <= 1'b1;
        end else if (rd_nmi) begin
            nmi_flag_r[`WRCRF_NMI_PIN_BIT] <= 1'b0;
        end
        if (nmi_watchdog_event) begin
            nmi_flag_r[`WRCRF_NMI_WDT_BIT] <= 1'b1;
        end else if (rd_nmi) begin
            nmi_flag_r[`WRCRF_NMI_WDT_BIT] <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------
// Reset cause flags
// ----------------------------------------------------------------------
reg cause_taken_r;
reg cause_now_r;
wire [4:0] cause_set;
wire [4:0] rst_keep;

// Causes are caught once, in the second cycle after system reset release
always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        cause_taken_r <= 1'b0;
        cause_now_r <= 1'b0;
    end else begin
        cause_taken_r <= 1'b1;
        cause_now_r <= !cause_taken_r;
    end
end
assign cause_set = {cause_now_r && cpu_soft_reset_request, 1'b0,
                    cause_now_r && reset_cause_watchdog,
                    cause_now_r && reset_cause_pin, 1'b0};
// Written zeros clear, written ones keep the old value
assign rst_keep = wr_hit_rstc ? (wdata_r[4:0] | ~wmask[4:0])
                              : 5'h1F;

// Power-on clears all but the power-up flag; system reset leaves them
always @(posedge clk or negedge pon_sync_r) begin
    if (!pon_sync_r) begin
        rst_flag_r <= `WRCRF_RST_PON_VAL;
    end else begin
        rst_flag_r <= ((rst_flag_r & rst_keep) | cause_set) &
                      `WRCRF_RST_USED;
    end
end

// ----------------------------------------------------------------------
// Interrupt status and mask
// ----------------------------------------------------------------------
wire [`WRCRF_IRQ_W-1:0] irq_evt;
wire [`WRCRF_IRQ_W-1:0] irq_w1c;

assign irq_evt = {|(wake_req_set & `WRCRF_SRC_VALID),
                  nmi_watchdog_event, nmi_pin_event};
assign irq_w1c = wr_hit_irqst ? (wdata_r[`WRCRF_IRQ_W-1:0] &
                                 wmask[`WRCRF_IRQ_W-1:0])
                              : {`WRCRF_IRQ_W{1'b0}};

// Sticky status, write one to clear, events win over clears
always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        irq_st_r <= {`WRCRF_IRQ_W{1'b0}};
        irq_msk_r <= {`WRCRF_IRQ_W{1'b0}};
    end else begin
        irq_st_r <= (irq_st_r & ~irq_w1c) | irq_evt;
        if (wr_hit_irqmsk && wstrb_r[0]) begin
            irq_msk_r <= wdata_r[`WRCRF_IRQ_W-1:0];
        end
    end
end

assign irq = |(irq_st_r & irq_msk_r);

endmodule // wrcrf_top

// *** wrcrf_chk.sv ***
// Checker for bus answers and wake request effects of the flag bank
`include "wrcrf_regs.vh"
module wrcrf_chk #(
    parameter NSRC = `WRCRF_NSRC
) (
    input wire clk,
    input wire reset_n,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [`WRCRF_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [NSRC-1:0] wake_req_set,
    input wire [NSRC-1:0] wake_pending,
    input wire [NSRC-1:0] wake_clear_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [NSRC-1:0] SRC_OK = `WRCRF_SRC_VALID;
    logic [`WRCRF_ADDR_W-1:0] rd_addr_r;
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Address of the read in flight
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_addr_r <= 5'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_r <= s_axi_araddr;
        end
    end
    AST_WAKE_SET: assert property ((wake_req_set & SRC_OK) != 0 |=>
        (wake_pending & $past(wake_req_set & SRC_OK))
        == $past(wake_req_set & SRC_OK)) else $error("wake request lost");
    AST_WAKE_CLR: assert property (
        (wake_clear_pulse & ~wake_req_set) != 0
        |=> (wake_pending & $past(wake_clear_pulse & ~wake_req_set)) == 0)
        else $error("wake request not cleared");
    AST_CLR_ONE: assert property ($onehot0(wake_clear_pulse))
        else $error("clear hit several sources");
    AST_CLR_RSVD: assert property (wake_clear_pulse[7:6] == 2'h0)
        else $error("reserved code cleared a source");
    AST_CLR_TIME: assert property (wake_clear_pulse != 0 |=>
        $rose(s_axi_bvalid)) else $error("clear pulse off its write");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
    AST_RD_CLR0: assert property (s_axi_rvalid && rd_addr_r[4:2] == 3'h0
        |-> s_axi_rdata == 32'h0) else $error("clear register not zero");
    AST_RD_NMI: assert property (s_axi_rvalid && rd_addr_r[4:2] == 3'h1
        |-> s_axi_rdata[31:2] == 30'h0) else $error("nmi upper bits set");
    AST_RD_RST: assert property (s_axi_rvalid && rd_addr_r[4:2] == 3'h2
        |-> s_axi_rdata[31:5] == 27'h0 && !s_axi_rdata[3])
        else $error("reset cause reserved bits set");
endmodule // wrcrf_chk
bind wrcrf_top wrcrf_chk #(.NSRC(NSRC)) i_wrcrf_chk (.clk, .reset_n,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .wake_req_set, .wake_pending, .wake_clear_pulse);

// *** wake_request_clear_and_reset_flags_bench.sv ***
// Self-checking bench of the wake request and reset flag bank
`include "wrcrf_regs.vh"
module wake_request_clear_and_reset_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, power_on_n, s_axi_awvalid, s_axi_wvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [10:0] wake_req_set, wake_pending, wake_clear_pulse, m;
    logic [21:0] wake_edge_in, active_edge_status;
    logic nmi_pin_event, nmi_watchdog_event, reset_cause_pin;
    logic reset_cause_watchdog, cpu_soft_reset_request;
    int fail_count = 0, n_compared = 0, stall = 0;
    // Rows: selector code in 15:11, pending set left after the clear
    localparam logic [15:0] ROWS [13] = '{16'h073E, 16'h0F3D, 16'h173B,
        16'h1F37, 16'h272F, 16'h2F1F, 16'h373F, 16'h3F3F, 16'h463F,
        16'h4D3F, 16'h533F, 16'h5F3F, 16'hFF3F};
    // ------------------------------------------------------------------
    // Device, clock, tasks
    // ------------------------------------------------------------------
    wrcrf_top i_wrcrf_top (.clk, .reset_n, .power_on_n, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .wake_req_set, .wake_edge_in, .wake_pending, .active_edge_status,
        .wake_clear_pulse, .nmi_pin_event, .nmi_watchdog_event,
        .reset_cause_pin, .reset_cause_watchdog, .cpu_soft_reset_request,
        .irq);
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] v);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (s_axi_awready && !ad) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !wd) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat (stall) @(posedge clk);
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        chk("write resp", {30'h0, `WRCRF_RESP_OKAY}, {30'h0, r});
    endtask
    task rd(input logic [4:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
        end while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat (stall) @(posedge clk);
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk("read resp", {30'h0, ((a > `WRCRF_OFS_IRQMSK) ?
            `WRCRF_RESP_SLVERR : `WRCRF_RESP_OKAY)}, {30'h0, r});
    endtask
    task pulse(input logic p, input logic w);
        @(posedge clk);
        nmi_pin_event <= p;
        nmi_watchdog_event <= w;
        @(posedge clk);
        nmi_pin_event <= 1'b0;
        nmi_watchdog_event <= 1'b0;
        @(posedge clk);
    endtask
    task do_reset(input logic pon);
        @(posedge clk);
        reset_n <= 1'b0;
        power_on_n <= !pon;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        power_on_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    function automatic logic [21:0] dbl(input logic [10:0] x);
        for (int i = 0; i < 11; i++)
            dbl[2*i+:2] = {2{x[i]}};
    endfunction
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fail_count++;
        end_sim;
    end
    // Main sequence: code table, then hand-written cases
    initial begin
        {reset_n, power_on_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
            s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr,
            s_axi_wdata, wake_req_set, nmi_pin_event, nmi_watchdog_event,
            reset_cause_pin, reset_cause_watchdog,
            cpu_soft_reset_request} = '0;
        s_axi_wstrb = 4'hF;
        wake_edge_in = 22'h3FFFFF;
        do_reset(1'b1);
        foreach (ROWS[i]) begin
            m = ROWS[i][10:0];
            @(posedge clk);
            wake_req_set <= 11'h7FF;
            @(posedge clk);
            wake_req_set <= 11'h000;
            wr(`WRCRF_OFS_CLEAR, {27'h0, ROWS[i][15:11]});
            repeat (2) @(posedge clk);
            chk("clear resp", 32'h0, {30'h0, r});
            chk("pending", {21'h0, m}, {21'h0, wake_pending});
            chk("edges", {10'h0, dbl(m)}, {10'h0, active_edge_status});
        end
        $display("clear code table done");
        stall = 2;
        rd(`WRCRF_OFS_RSTC);
        chk("cause", 32'h01, d);
        rd(`WRCRF_OFS_CLEAR);
        chk("clear read", 32'h0, d);
        wr(`WRCRF_OFS_RSTC, 32'h17);
        rd(`WRCRF_OFS_RSTC);
        chk("cause", 32'h01, d);
        {reset_cause_pin, reset_cause_watchdog,
            cpu_soft_reset_request} <= 3'h7;
        do_reset(1'b0);
        {reset_cause_pin, reset_cause_watchdog,
            cpu_soft_reset_request} <= 3'h0;
        rd(`WRCRF_OFS_RSTC);
        chk("cause", 32'h17, d);
        wr(`WRCRF_OFS_RSTC, 32'h13);
        rd(`WRCRF_OFS_RSTC);
        chk("cause", 32'h13, d);
        wr(`WRCRF_OFS_RSTC, 32'h0);
        repeat (20) @(posedge clk);
        rd(`WRCRF_OFS_RSTC);
        chk("cause", 32'h0, d);
        $display("reset cause tests done");
        pulse(1'b1, 1'b0);
        rd(`WRCRF_OFS_NMI);
        chk("nmi", 32'h2, d);
        rd(`WRCRF_OFS_NMI);
        chk("nmi", 32'h0, d);
        pulse(1'b0, 1'b1);
        rd(`WRCRF_OFS_NMI);
        chk("nmi", 32'h1, d);
        $display("nmi flag tests done");
        wr(`WRCRF_OFS_IRQST, 32'h7);
        wr(`WRCRF_OFS_IRQMSK, 32'h1);
        pulse(1'b0, 1'b1);
        chk("irq masked", 32'h0, {31'h0, irq});
        pulse(1'b1, 1'b0);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`WRCRF_OFS_IRQST, 32'h1);
        @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(`WRCRF_OFS_IRQST);
        chk("irq status", 32'h2, d);
        wake_req_set <= 11'h001;
        @(posedge clk);
        wake_req_set <= 11'h000;
        rd(`WRCRF_OFS_IRQST);
        chk("irq wake status", 32'h6, d);
        rd(5'h14);
        chk("unmapped resp", 32'h2, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        $display("interrupt and bus tests done");
        end_sim;
    end
endmodule // wake_request_clear_and_reset_flags_bench
